// ---- rtl/status_system_diagnosis_readback.sv ----
`timescale 1ns/1ps
`include "sbc_defines.svh"

// Operation
// - Wake falling edge sets status bit 4; a status read clears it.
// - Status bit 3 follows the temperature-warning condition.
// - Status bit 2 shows development mode; it blocks supervision except long undervoltage.
// - Status bit 1 shows whether the enable pin is driven high.
// - Power-on reset sets status bit 0; entering Normal or Flash clears it.
// - Reset-cause field takes every reset cause and is never cleared.
// - Address 00 with select bit 13 high returns the diagnosis word.
// - Bit 12 high reads only; low also writes payload to mode register.
// - Diagnosis bit 11 shows ground offset beyond threshold.
// - Diagnosis bits 10 to 7 carry the CAN fault code.
// - Diagnosis bits 6 and 5 carry the LIN fault code.
// - Third supply bit drops on short, returns when switched on again.
// - Overload on active second supply clears its bit and disables it.
// - Listed CAN events restart second supply and set its bit.
// - Main supply bit drops on retention undervoltage; diagnosis read sets it.
// - Diagnosis bits 1 and 0 report the CAN transceiver state.
// - Address 00 with select bit 13 low returns the status word.
module status_system_diagnosis_readback
  import sbc_status_pkg::*;
#(
  parameter int unsigned UV_HOLD = `UV_HOLD_CYC
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // Serial register port
  input wire logic SPI_CLK,
  input wire logic SPI_CS_N,
  input wire logic SPI_DIN,
  output logic SPI_DOUT,
  output logic SPI_DOUT_OE_N,
  // Mode register write
  output mode_wr_s MODE_WRITE,
  // Status sources
  input wire logic WAKE_IN,
  input wire logic TEMP_WARN,
  input wire logic DEV_MODE,
  input wire logic EN_DRIVEN,
  input wire logic POR_EVENT,
  input wire logic MODE_ENTERED,
  input wire logic RESET_EVENT,
  input wire logic [3:0] RESET_CAUSE,
  // Diagnosis sources
  input wire phy_fault_s PHY_FAULT,
  input wire supply_evt_s SUPPLY_EVT,
  input wire logic CAN_TX_DISABLE,
  input wire can_state_e CAN_STATE,
  input wire logic V1_RETENTION_LOW,
  input wire logic V1_UNDERVOLT,
  // Supervision
  input wire logic MON_FAULT,
  input wire logic FAILSAFE_REQ,
  output logic MON_RESET,
  output logic FAILSAFE_GO,
  output logic V2_ENABLE
);

  top_s st;
  top_s next_st;
  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;
  logic uv_fire;

  // Word chosen by the frame header
  function automatic logic [11:0] read_word(
    input logic [3:0] hdr,
    input top_s s
  );
    status_word_s sw;
    system_diagnosis_word_s dw;
    logic [11:0] w;
    sw = s.stat;
    dw = s.system_diagnosis;
    // Reserved status bits never leak state
    sw.rsvd7 = 1'b0;
    sw.rsvd5 = 1'b0;
    w = 12'h000;
    if (hdr[3:2] == `SYS_ADDR) begin
      if (hdr[1]) begin
        w = dw;
      end else begin
        w = sw;
      end
    end
    return w;
  endfunction

  // Levels watched for edges
  assign lvl = {SPI_CS_N, SPI_CLK, CAN_TX_DISABLE, WAKE_IN};

  edge_bank #(
    .IDLE(`EDGE_IDLE)
  ) u_edges (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  // Main supply undervoltage longer than the hold time
  hold_timer #(
    .HOLD(24'(UV_HOLD))
  ) u_uv_hold (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .active(V1_UNDERVOLT),
    .fire(uv_fire)
  );

  always_comb begin
    logic [3:0] hdr;
    logic commit;
    logic sys_hit;
    logic rd_stat;
    logic rd_system_diagnosis;
    logic v2_restart;
    logic off_exit;
    logic snap;
    logic online_exit;
    logic sleep_exit;
    logic mode_evt;
    logic ctc_evt;
    logic sup_ok;
    logic wr_mode;

    hdr = {st.frm.rx[2:0], SPI_DIN};
    commit = 1'b0;
    sys_hit = 1'b0;
    rd_stat = 1'b0;
    rd_system_diagnosis = 1'b0;
    v2_restart = 1'b0;
    off_exit = 1'b0;
    snap = 1'b0;
    online_exit = 1'b0;
    sleep_exit = 1'b0;
    mode_evt = 1'b0;
    ctc_evt = 1'b0;
    sup_ok = 1'b0;
    wr_mode = 1'b0;

    next_st = st;
    next_st.mode.valid = 1'b0;
    next_st.mon_reset = 1'b0;
    next_st.failsafe_go = 1'b0;

    // Serial frame: sample on SCK rise, shift answer on SCK fall
    case (st.frm.fstate)
      FR_IDLE: begin
        if (fall[`EB_CS]) begin
          next_st.frm.fstate = FR_BUSY;
          next_st.frm.bit_cnt = 5'h00;
          next_st.frm.tx = 16'h0000;
          next_st.frm.late = 2'h0;
          next_st.frm.oe_n = 1'b0;
        end else begin
          next_st.frm.oe_n = 1'b1;
          next_st.frm.late = 2'h0;
        end
      end
      FR_BUSY: begin
        if (rise[`EB_CS]) begin
          next_st.frm.fstate = FR_IDLE;
          next_st.frm.oe_n = 1'b1;
          // Refused frames leave no trace
          next_st.frm.late = 2'h0;
          commit = (st.frm.bit_cnt == `FRM_BITS);
        end else if (rise[`EB_SCK]) begin
          next_st.frm.rx = {st.frm.rx[14:0], SPI_DIN};
          if (st.frm.bit_cnt != `CNT_MAX) begin
            next_st.frm.bit_cnt = st.frm.bit_cnt + 5'h01;
          end
          if (st.frm.bit_cnt == `HDR_BITS - 5'h01) begin
            snap = 1'b1;
            next_st.frm.tx = {1'b0, read_word(hdr, st), 3'h0};
          end
        end else if (fall[`EB_SCK] && st.frm.bit_cnt != 5'h00) begin
          next_st.frm.tx = {st.frm.tx[14:0], 1'b0};
        end
        // Events from the snapshot cycle on must survive the read
        if ((st.frm.bit_cnt >= `HDR_BITS) || snap) begin
          if (fall[`EB_WAKE]) begin
            next_st.frm.late[0] = 1'b1;
          end
          if (V1_RETENTION_LOW) begin
            next_st.frm.late[1] = 1'b1;
          end
        end
      end
      default: begin
        next_st.frm.fstate = FR_IDLE;
        next_st.frm.oe_n = 1'b1;
        next_st.frm.bit_cnt = 5'h00;
        next_st.frm.late = 2'h0;
      end
    endcase

    // Completed frames to address 00
    sys_hit = commit && (st.frm.rx[`ADDR_HI:`ADDR_LO] == `SYS_ADDR);
    rd_stat = sys_hit && !st.frm.rx[`SEL_BIT];
    rd_system_diagnosis = sys_hit && st.frm.rx[`SEL_BIT];
    // Mode register write on writable frames
    wr_mode = sys_hit && !st.frm.rx[`RO_BIT];
    if (wr_mode) begin
      next_st.mode.valid = 1'b1;
      next_st.mode.data = st.frm.rx[11:0];
    end

    // Status word levels
    next_st.stat.rsvd7 = 1'b0;
    next_st.stat.rsvd5 = 1'b0;
    next_st.stat.wake_level = WAKE_IN;
    next_st.stat.temp_warning_flag = TEMP_WARN;
    next_st.stat.dev_mode_flag = DEV_MODE;
    next_st.stat.en_flag = EN_DRIVEN;

    // Wake edge: read clears, a new edge wins
    if (rd_stat) begin
      next_st.stat.wake_edge_flag = st.frm.late[0];
    end
    if (fall[`EB_WAKE]) begin
      next_st.stat.wake_edge_flag = 1'b1;
    end

    // Power-on flag: set wins over clear
    if (MODE_ENTERED) begin
      next_st.stat.power_on_flag = 1'b0;
    end
    if (POR_EVENT) begin
      next_st.stat.power_on_flag = 1'b1;
    end

    // Most recent reset cause, never cleared
    if (RESET_EVENT) begin
      next_st.stat.last_reset_cause = RESET_CAUSE;
    end
    if (POR_EVENT) begin
      next_st.stat.last_reset_cause = `CAUSE_POR;
    end

    // Physical layer fault reports
    next_st.system_diagnosis.ground_offset_flag = PHY_FAULT.ground_offset;
    next_st.system_diagnosis.can_fault_code = PHY_FAULT.can_fault;
    next_st.system_diagnosis.lin_fault_code = PHY_FAULT.lin_fault;
    next_st.system_diagnosis.can_state_report = CAN_STATE;

    // Third supply: short wins over switch-on
    if (SUPPLY_EVT.v3_switch_on) begin
      next_st.system_diagnosis.third_supply_ok = 1'b1;
    end
    if (SUPPLY_EVT.v3_short) begin
      next_st.system_diagnosis.third_supply_ok = 1'b0;
    end

    // Second supply restart events
    mode_evt = SUPPLY_EVT.can_mode_set;
    ctc_evt = fall[`EB_CTC];
    online_exit = (st.system_diagnosis.can_state_report == CAN_OFFLINE) && (CAN_STATE == CAN_ONLINE);
    sleep_exit = (st.system_diagnosis.can_state_report == CAN_OFFLINE) && (CAN_STATE == CAN_SEL_SLEEP);
    off_exit = online_exit || sleep_exit;
    v2_restart = mode_evt || ctc_evt || off_exit;
    if (v2_restart) begin
      next_st.system_diagnosis.second_supply_ok = 1'b1;
      next_st.v2_enable = 1'b1;
    end
    if (SUPPLY_EVT.v2_overload && st.v2_enable) begin
      next_st.system_diagnosis.second_supply_ok = 1'b0;
      next_st.v2_enable = 1'b0;
    end

    // Main supply: diagnosis read sets, dip wins
    if (rd_system_diagnosis) begin
      next_st.system_diagnosis.main_supply_ok = ~st.frm.late[1];
    end
    if (V1_RETENTION_LOW) begin
      next_st.system_diagnosis.main_supply_ok = 1'b0;
    end

    // Supervision gated by development mode, except the long undervoltage fail-safe
    sup_ok = !st.stat.dev_mode_flag;
    next_st.mon_reset = MON_FAULT && sup_ok;
    next_st.failsafe_go = (FAILSAFE_REQ && sup_ok) || uv_fire;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st.stat.rsvd7 <= 1'b0;
      st.stat.wake_level <= 1'b0;
      st.stat.rsvd5 <= 1'b0;
      st.stat.wake_edge_flag <= 1'b0;
      st.stat.temp_warning_flag <= 1'b0;
      st.stat.dev_mode_flag <= 1'b0;
      st.stat.en_flag <= 1'b0;
      st.system_diagnosis.ground_offset_flag <= 1'b0;
      st.system_diagnosis.can_fault_code <= 4'h0;
      st.system_diagnosis.lin_fault_code <= 2'h0;
      st.frm.bit_cnt <= 5'h00;
      st.frm.rx <= 16'h0000;
      st.frm.tx <= 16'h0000;
      st.frm.late <= 2'h0;
      st.mode.valid <= 1'b0;
      st.mode.data <= 12'h000;
      st.mon_reset <= 1'b0;
      st.failsafe_go <= 1'b0;

      // Sticky flags and supplies start set
      st.stat.last_reset_cause <= `CAUSE_POR;
      st.stat.power_on_flag <= `POR_FLAG_RST;
      st.system_diagnosis.third_supply_ok <= `SUPPLY_OK_RST;
      st.system_diagnosis.second_supply_ok <= `SUPPLY_OK_RST;
      st.system_diagnosis.main_supply_ok <= `SUPPLY_OK_RST;
      st.system_diagnosis.can_state_report <= CAN_OFFLINE;
      st.frm.fstate <= FR_IDLE;
      st.frm.oe_n <= `OE_N_RST;
      st.v2_enable <= `V2_EN_RST;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign SPI_DOUT = st.frm.tx[15];
  assign SPI_DOUT_OE_N = st.frm.oe_n;

  // Mode strobe and supervision
  assign MODE_WRITE = st.mode;
  assign MON_RESET = st.mon_reset;
  assign FAILSAFE_GO = st.failsafe_go;
  assign V2_ENABLE = st.v2_enable;

endmodule // status_system_diagnosis_readback

// ---- common/sbc_defines.svh ----
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// Serial frame layout
`define FRM_BITS 5'h10
`define HDR_BITS 5'h04
`define CNT_MAX 5'h1F
`define ADDR_HI 15
`define ADDR_LO 14
`define SEL_BIT 13
`define RO_BIT 12
`define SYS_ADDR 2'h0

// Edge detector lanes
`define EB_WAKE 0
`define EB_CTC 1
`define EB_SCK 2
`define EB_CS 3
`define EDGE_IDLE 4'h9

// Reset values
`define CAUSE_POR 4'h0
`define POR_FLAG_RST 1'h1
`define SUPPLY_OK_RST 1'h1
`define V2_EN_RST 1'h1
`define OE_N_RST 1'h1

// Timing
`define CLK_KHZ 40000
`define UV_HOLD_MS 256
`define UV_HOLD_CYC (`UV_HOLD_MS * `CLK_KHZ)

`endif

// ---- common/sbc_status_pkg.sv ----
package sbc_status_pkg;

  typedef enum logic [1:0] {
    CAN_OFFLINE = 2'b00,
    CAN_SEL_SLEEP = 2'b01,
    CAN_ONLINE = 2'b10,
    CAN_ACTIVE = 2'b11
  } can_state_e;

  typedef enum logic [0:0] {
    FR_IDLE = 1'b0,
    FR_BUSY = 1'b1
  } frame_state_e;

  typedef struct packed {
    logic [3:0] last_reset_cause;
    logic rsvd7;
    logic wake_level;
    logic rsvd5;
    logic wake_edge_flag;
    logic temp_warning_flag;
    logic dev_mode_flag;
    logic en_flag;
    logic power_on_flag;
  } status_word_s;

  typedef struct packed {
    logic ground_offset_flag;
    logic [3:0] can_fault_code;
    logic [1:0] lin_fault_code;
    logic third_supply_ok;
    logic second_supply_ok;
    logic main_supply_ok;
    can_state_e can_state_report;
  } system_diagnosis_word_s;

  typedef struct packed {
    logic ground_offset;
    logic [3:0] can_fault;
    logic [1:0] lin_fault;
  } phy_fault_s;

  typedef struct packed {
    logic v3_short;
    logic v3_switch_on;
    logic v2_overload;
    logic can_mode_set;
  } supply_evt_s;

  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } mode_wr_s;

  typedef struct packed {
    frame_state_e fstate;
    logic [4:0] bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [1:0] late;
    logic oe_n;
  } frame_s;

  typedef struct packed {
    status_word_s stat;
    system_diagnosis_word_s system_diagnosis;
    frame_s frm;
    mode_wr_s mode;
    logic v2_enable;
    logic mon_reset;
    logic failsafe_go;
  } top_s;

  typedef struct packed {
    logic [3:0] prev;
  } edge_s;

  typedef struct packed {
    logic [23:0] cnt;
  } timer_s;

endpackage

// ---- rtl/edge_bank.sv ----
`timescale 1ns/1ps
`include "sbc_defines.svh"

module edge_bank
  import sbc_status_pkg::*;
#(
  parameter logic [3:0] IDLE = `EDGE_IDLE
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Sampled levels
  input wire logic [3:0] lvl,
  // Edge pulses
  output logic [3:0] rise,
  output logic [3:0] fall
);

  edge_s st;
  edge_s next_st;

  always_comb begin
    next_st = st;
    next_st.prev = lvl;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st.prev <= IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_bit
    assign rise[i] = ce & lvl[i] & ~st.prev[i];
    assign fall[i] = ce & ~lvl[i] & st.prev[i];
  end

endmodule // edge_bank

// ---- rtl/hold_timer.sv ----
`timescale 1ns/1ps

module hold_timer
  import sbc_status_pkg::*;
#(
  parameter logic [23:0] HOLD = 24'h000010
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Condition and expiry pulse
  input wire logic active,
  output logic fire
);

  timer_s st;
  timer_s next_st;

  // Saturates so the pulse comes once per episode
  always_comb begin
    next_st = st;
    if (!active) begin
      next_st.cnt = 24'h000000;
    end else if (st.cnt != HOLD) begin
      next_st.cnt = st.cnt + 24'h000001;
    end
  end

  assign fire = ce & active & (st.cnt == HOLD - 24'h000001);

  always_ff @(posedge clk) begin
    if (rst) begin
      st.cnt <= 24'h000000;
    end else if (ce) begin
      st <= next_st;
    end
  end

endmodule // hold_timer

// ---- test/spi_host.sv ----
`timescale 1ns/1ps

module spi_host (
  // Clock and answer line
  input wire logic clk,
  input wire logic dout,
  // Frame lines
  output logic sck,
  output logic cs_n,
  output logic din
);
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    din = 1'h1;
  end

  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  task automatic xfer(input logic [15:0] f, input int n, output logic [11:0] r);
    r = 12'h000;
    cs_n = 1'h0;
    half();
    for (int i = 0; i < n; i++) begin
      din = f[15 - i];
      half();
      if (i >= 4) r = {r[10:0], dout};
      sck = 1'h1;
      half();
      sck = 1'h0;
    end
    half();
    cs_n = 1'h1;
    // Released line shows the inverse
    din = ~din;
    half();
    half();
  endtask
endmodule // spi_host

// ---- test/status_system_diagnosis_readback_properties.sv ----
`timescale 1ns/1ps

module status_system_diagnosis_readback_properties
  import sbc_status_pkg::*;
#(
  parameter int unsigned UV_HOLD = 20
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // Watched ports
  input wire mode_wr_s MODE_WRITE,
  input wire logic SPI_CS_N,
  input wire supply_evt_s SUPPLY_EVT,
  input wire logic CAN_TX_DISABLE,
  input wire logic V1_UNDERVOLT,
  input wire logic MON_FAULT,
  input wire logic FAILSAFE_REQ,
  input wire logic MON_RESET,
  input wire logic FAILSAFE_GO,
  input wire logic V2_ENABLE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST || !CE);

  logic [7:0] uv_cnt;
  always_ff @(posedge CLK_SYS) begin
    if (RST || !V1_UNDERVOLT) uv_cnt <= 8'h00;
    else if (CE && uv_cnt != 8'hFF) uv_cnt <= uv_cnt + 8'h01;
  end

  a_mon_cause: assert property (MON_RESET |-> $past(MON_FAULT))
    else $error("monitor reset without fault");
  a_fs_cause: assert property (FAILSAFE_GO |-> $past(FAILSAFE_REQ) || $past(V1_UNDERVOLT))
    else $error("fail-safe without cause");
  a_uv_expiry: assert property ((32'(uv_cnt) == UV_HOLD) |-> ##[0:2] FAILSAFE_GO)
    else $error("long undervoltage ignored");
  a_write_pulse: assert property (MODE_WRITE.valid |-> SPI_CS_N ##1 !MODE_WRITE.valid)
    else $error("mode write not a single pulse");
  a_v2_overload: assert property (SUPPLY_EVT.v2_overload && V2_ENABLE |=> !V2_ENABLE)
    else $error("overload kept second supply on");
  a_v2_off_cause: assert property ($fell(V2_ENABLE) |-> $past(SUPPLY_EVT.v2_overload))
    else $error("second supply off without overload");
  a_v2_mode_set: assert property (SUPPLY_EVT.can_mode_set && !SUPPLY_EVT.v2_overload |=> V2_ENABLE)
    else $error("mode set did not restart");
  a_v2_tx_fall: assert property ($fell(CAN_TX_DISABLE) && !SUPPLY_EVT.v2_overload |-> ##[1:2] V2_ENABLE)
    else $error("transmitter enable did not restart");
endmodule // status_system_diagnosis_readback_properties

bind status_system_diagnosis_readback status_system_diagnosis_readback_properties #(.UV_HOLD(UV_HOLD)) props_inst (
  .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .MODE_WRITE(MODE_WRITE), .SPI_CS_N(SPI_CS_N),
  .SUPPLY_EVT(SUPPLY_EVT), .CAN_TX_DISABLE(CAN_TX_DISABLE), .V1_UNDERVOLT(V1_UNDERVOLT),
  .MON_FAULT(MON_FAULT), .FAILSAFE_REQ(FAILSAFE_REQ), .MON_RESET(MON_RESET),
  .FAILSAFE_GO(FAILSAFE_GO), .V2_ENABLE(V2_ENABLE));

// ---- test/status_system_diagnosis_readback_tb.sv ----
`timescale 1ns/1ps

module status_system_diagnosis_readback_tb;
  import sbc_status_pkg::*;
  localparam int LIMIT = 20000;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic sck, cs_n, din, dout, oe_n, mon_rst, fs_go, v2en;
  logic wake, temp, dev, en, por, ment, rev, can_tx_disable, ret, uv, monf, fsr;
  logic [3:0] cause;
  logic [11:0] wr_data;
  logic [15:0] n_wr = 16'h0000, n_mr = 16'h0000, n_fs = 16'h0000;
  phy_fault_s pf;
  supply_evt_s se;
  can_state_e st;
  mode_wr_s mw;
  int num_errors = 0, checked = 0, cyc_cnt = 0;

  always #12.5 clk_sys = ~clk_sys;

  spi_host spi_host_inst (.clk(clk_sys), .dout(dout), .sck(sck), .cs_n(cs_n), .din(din));
  status_system_diagnosis_readback #(.UV_HOLD(20)) status_system_diagnosis_readback_inst (
    .CLK_SYS(clk_sys), .RST(rst), .CE(1'h1), .SPI_CLK(sck), .SPI_CS_N(cs_n),
    .SPI_DIN(din), .SPI_DOUT(dout), .SPI_DOUT_OE_N(oe_n), .MODE_WRITE(mw),
    .WAKE_IN(wake), .TEMP_WARN(temp), .DEV_MODE(dev), .EN_DRIVEN(en), .POR_EVENT(por),
    .MODE_ENTERED(ment), .RESET_EVENT(rev), .RESET_CAUSE(cause), .PHY_FAULT(pf),
    .SUPPLY_EVT(se), .CAN_TX_DISABLE(can_tx_disable), .CAN_STATE(st), .V1_RETENTION_LOW(ret),
    .V1_UNDERVOLT(uv), .MON_FAULT(monf), .FAILSAFE_REQ(fsr), .MON_RESET(mon_rst),
    .FAILSAFE_GO(fs_go), .V2_ENABLE(v2en));

  task automatic summarize();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (mw.valid === 1'h1) begin
      n_wr++;
      wr_data = mw.data;
    end
    if (mon_rst === 1'h1) n_mr++;
    if (fs_go === 1'h1) n_fs++;
    if (cyc_cnt == LIMIT) begin
      num_errors++;
      summarize();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] f, input logic [11:0] exp);
    logic [11:0] r;
    spi_host_inst.xfer(f, 16, r);
    chk(16'(r), 16'(exp));
    chk(16'(oe_n), 16'h0001);
  endtask

  task automatic t_stat();
    rd(16'h1000, 12'h041);
    temp = 1'h1;
    dev = 1'h1;
    en = 1'h1;
    wake = 1'h0;
    cyc(3);
    wake = 1'h1;
    cyc(3);
    rd(16'h1000, 12'h05F);
    rd(16'h1000, 12'h04F);
    ment = 1'h1;
    cause = 4'hB;
    rev = 1'h1;
    cyc(1);
    {ment, rev} = 2'h0;
    rd(16'h1000, 12'hB4E);
    cause = 4'h3;
    rev = 1'h1;
    cyc(1);
    rev = 1'h0;
    rd(16'h1000, 12'h34E);
    por = 1'h1;
    cyc(1);
    por = 1'h0;
    rd(16'h1000, 12'h04F);
    $display("status test done");
  endtask

  task automatic t_wr();
    logic [11:0] r;
    rd(16'h0A5C, 12'h04F);
    chk(n_wr, 16'h0001);
    chk(16'(wr_data), 16'h0A5C);
    spi_host_inst.xfer(16'h0123, 15, r);
    rd(16'h4123, 12'h000);
    chk(n_wr, 16'h0001);
    rd(16'h2ABC, 12'h01C);
    chk(n_wr, 16'h0002);
    chk(16'(wr_data), 16'h0ABC);
    $display("write test done");
  endtask

  task automatic t_system_diagnosis();
    for (int i = 0; i < 16; i++) begin
      pf = {i[0], i[3:0], i[2:1]};
      st = can_state_e'(i[1:0]);
      cyc(3);
      rd(16'h3000, {pf, 3'h7, i[1:0]});
    end
    pf = '0;
    st = CAN_OFFLINE;
    $display("system_diagnosis test done");
  endtask

  task automatic t_sup();
    se.v3_short = 1'h1;
    cyc(1);
    se.v3_short = 1'h0;
    rd(16'h3000, 12'h00C);
    rd(16'h3000, 12'h00C);
    se.v3_switch_on = 1'h1;
    cyc(1);
    se.v3_switch_on = 1'h0;
    rd(16'h3000, 12'h01C);
    for (int k = 0; k < 4; k++) begin
      se.v2_overload = 1'h1;
      cyc(1);
      se.v2_overload = 1'h0;
      cyc(2);
      chk(16'(v2en), 16'h0000);
      if (k == 0) rd(16'h3000, 12'h014);
      case (k)
        0: se.can_mode_set = 1'h1;
        1: can_tx_disable = 1'h1;
        default: st = k[0] ? CAN_SEL_SLEEP : CAN_ONLINE;
      endcase
      cyc(1);
      se.can_mode_set = 1'h0;
      can_tx_disable = 1'h0;
      st = CAN_OFFLINE;
      cyc(3);
      chk(16'(v2en), 16'h0001);
    end
    rd(16'h3000, 12'h01C);
    ret = 1'h1;
    cyc(1);
    ret = 1'h0;
    rd(16'h3000, 12'h018);
    rd(16'h3000, 12'h01C);
    $display("supply test done");
  endtask

  task automatic t_uv();
    {monf, fsr} = 2'h3;
    cyc(1);
    {monf, fsr} = 2'h0;
    cyc(3);
    chk(n_mr, 16'h0000);
    chk(n_fs, 16'h0000);
    uv = 1'h1;
    cyc(30);
    uv = 1'h0;
    cyc(2);
    chk(n_fs, 16'h0001);
    dev = 1'h0;
    cyc(2);
    {monf, fsr} = 2'h3;
    cyc(1);
    {monf, fsr} = 2'h0;
    cyc(3);
    chk(n_mr, 16'h0001);
    chk(n_fs, 16'h0002);
    $display("supervision test done");
  endtask

  initial begin
    {temp, dev, en, por, ment, rev, can_tx_disable, ret, uv, monf, fsr} = '0;
    wake = 1'h1;
    cause = 4'h0;
    pf = '0;
    se = '0;
    st = CAN_OFFLINE;
    cyc(20);
    rst = 1'h0;
    cyc(2);
    rd(16'h3000, 12'h01C);
    t_stat();
    t_wr();
    t_system_diagnosis();
    t_sup();
    t_uv();
    summarize();
  end
endmodule // status_system_diagnosis_readback_tb
